/* logic/ddms_supervisor.sv */
// Purpose: Mode, profile and overload supervision of a sliding-door drive
// Assumes: Motor state inputs synchronous to clk_i; AXI4-Lite register access
// Notes:   Long timer counts are parameters so a bench can shorten them
// How it works
// - Two profiles, alternate with own limits
// - Alternate only with order in normal mode
// - Profile change in travel brakes, then resumes
// - Initial and learn use own limits
// - Slow only with order in normal mode
// - Slow entry decelerates, at least 500
// - Slow exit accelerates at 1500
// - Initial and learn speed ignore slow
// - Sensor, order and blocking enter normal
// - Local input has one function only
// - Image sensor valid only in operation
// - Restart enters initial until both stops
// - Initial speed from per-direction parameters
// - Initial force limit includes friction
// - End-stop tolerance from its parameter
// - Overload shows code 4 on display
// - Short dwell lengthens hold-open time
// - Long one-way travel faults until reset, acknowledge raises restart
// - Long block reduces current until motion
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "ddms_regs.svh"

module ddms_supervisor #(
  parameter longint RUN_CYC   = `DDMS_RUN_CYC,
  parameter longint BLOCK_CYC = `DDMS_BLOCK_CYC,
  parameter longint DWELL_CYC = `DDMS_DWELL_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   ce_i,
  input  wire ddms_pkg::ddms_order_t  image_order_i,
  input  wire ddms_pkg::ddms_order_t  dig_order_i,
  input  wire logic                   use_image_i,
  input  wire logic                   in_operation_i,
  input  wire logic                   local_input_i,
  input  wire logic                   moving_i,
  input  wire logic                   standstill_i,
  input  wire logic                   blocked_i,
  input  wire logic                   in_obstr_area_i,
  input  wire logic                   motion_fwd_i,
  input  wire logic                   friction_i,
  input  wire logic [31:0]            friction_force_i,
  input  wire logic                   at_open_stop_i,
  input  wire logic                   at_close_stop_i,
  input  wire logic                   in_open_tol_i,
  input  wire logic                   in_close_tol_i,
  input  wire logic [11:0]            awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [11:0]            araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  output ddms_pkg::ddms_profile_t     profile_o,
  output logic [31:0]                 tolerance_o,
  output logic                        drive_enable_o,
  output logic                        current_nominal_o,
  output logic                        hold_extend_o,
  output logic                        restart_o,
  output logic [3:0]                  seg_code_o,
  output logic                        light_curtain_o,
  output logic                        light_barrier_o,
  output logic                        press_edge_o,
  output logic [1:0]                  state_o
);
  import ddms_pkg::*;

  ddms_state_t   state_r;
  ddms_order_t   ord;
  ddms_insel_t   insel_r;
  logic [31:0]   par_r [0:12];
  logic          alt_r, slow_r, ack_r;
  logic          open_ok_r, close_ok_r;
  logic          run_flt_r, blk_flt_r, dwell_flt_r;
  logic [39:0]   run_cnt_r, blk_cnt_r, dwell_cnt_r;
  logic          dir_r;
  logic          sensor;
  logic          want_alt, want_slow;
  logic          aw_got_r, w_got_r;
  logic [11:0]   aw_addr_r;
  logic [31:0]   w_data_r;
  logic [3:0]    w_strb_r;
  logic [3:0]    widx, ridx;
  logic          wmap, rmap;

  ////////////////////////////////////////////////////////////////////////////
  // Order selection and sensor routing

  always_comb begin
    ord = use_image_i ? image_order_i : dig_order_i;
    if (ord.open) begin
      ord.close = 1'b0;
    end
  end

  always_comb begin
    sensor = 1'b0;
    if (insel_r == DDMS_IN_END_SENSOR) begin
      sensor = local_input_i;
    end
    if (use_image_i && in_operation_i && image_order_i.end_sensor) begin
      sensor = 1'b1;
    end
  end

  assign light_curtain_o = (insel_r == DDMS_IN_LIGHT_CURTN) && local_input_i;
  assign light_barrier_o = (insel_r == DDMS_IN_LIGHT_BARR) && local_input_i;
  assign press_edge_o    = (insel_r == DDMS_IN_PRESS_EDGE) && local_input_i;

  assign want_alt  = ord.alt_profile && (ord.open || ord.close);
  assign want_slow = ord.slow && (ord.open || ord.close);

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r    <= DDMS_ST_INITIAL;
      open_ok_r  <= 1'b0;
      close_ok_r <= 1'b0;
    end else if (ce_i) begin
      case (state_r)
        DDMS_ST_INITIAL: begin
          if (at_open_stop_i && in_open_tol_i) begin
            open_ok_r <= 1'b1;
          end
          if (at_close_stop_i && in_close_tol_i) begin
            close_ok_r <= 1'b1;
          end
          if (sensor && (ord.open || ord.close) && blocked_i) begin
            state_r <= DDMS_ST_NORMAL;
          end else if (open_ok_r && close_ok_r) begin
            state_r <= DDMS_ST_NORMAL;
          end
        end
        DDMS_ST_NORMAL: begin
          if (moving_i && (want_alt != alt_r)) begin
            state_r <= DDMS_ST_BRAKE;
          end
        end
        DDMS_ST_BRAKE: begin
          if (standstill_i) begin
            state_r <= DDMS_ST_NORMAL;
          end
        end
        DDMS_ST_FAULT: begin
          state_r <= DDMS_ST_FAULT;
        end
        default: begin
          state_r <= DDMS_ST_INITIAL;
        end
      endcase
      if (run_flt_r) begin
        state_r <= DDMS_ST_FAULT;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      alt_r  <= 1'b0;
      slow_r <= 1'b0;
    end else if (ce_i) begin
      if (state_r != DDMS_ST_NORMAL) begin
        slow_r <= 1'b0;
        if (state_r != DDMS_ST_BRAKE) begin
          alt_r <= 1'b0;
        end else if (standstill_i) begin
          alt_r <= want_alt;
        end
      end else begin
        slow_r <= want_slow;
        if (!moving_i) begin
          alt_r <= want_alt;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overload timers

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_cnt_r <= '0;
      run_flt_r <= 1'b0;
      dir_r     <= 1'b0;
    end else if (ce_i) begin
      dir_r <= ord.open;
      if (!moving_i || (dir_r != ord.open)) begin
        run_cnt_r <= '0;
      end else if (run_cnt_r < 40'(RUN_CYC)) begin
        run_cnt_r <= run_cnt_r + 40'd1;
      end else begin
        run_flt_r <= 1'b1;
      end
    end
  end

  assign restart_o = run_flt_r && ack_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      blk_cnt_r <= '0;
      blk_flt_r <= 1'b0;
    end else if (ce_i) begin
      if (motion_fwd_i) begin
        blk_cnt_r <= '0;
        blk_flt_r <= 1'b0;
      end else if (blocked_i && !in_obstr_area_i) begin
        if (blk_cnt_r < 40'(BLOCK_CYC)) begin
          blk_cnt_r <= blk_cnt_r + 40'd1;
        end else begin
          blk_flt_r <= 1'b1;
        end
      end else begin
        blk_cnt_r <= '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dwell_cnt_r <= '0;
      dwell_flt_r <= 1'b0;
    end else if (ce_i) begin
      if (at_open_stop_i || at_close_stop_i) begin
        if (dwell_cnt_r < 40'(DWELL_CYC)) begin
          dwell_cnt_r <= dwell_cnt_r + 40'd1;
        end
      end else if (moving_i && dwell_cnt_r != '0) begin
        dwell_flt_r <= (dwell_cnt_r < 40'(DWELL_CYC));
        dwell_cnt_r <= '0;
      end
    end
  end

  assign hold_extend_o     = dwell_flt_r;
  assign current_nominal_o = blk_flt_r;
  assign drive_enable_o    = (state_r != DDMS_ST_FAULT) && !run_flt_r;
  assign seg_code_o = (run_flt_r || blk_flt_r || dwell_flt_r) ? `DDMS_SEG_OVERLOAD
                                                             : `DDMS_SEG_BLANK;
  assign state_o = (state_r == DDMS_ST_INITIAL) ? 2'd0 :
                   (state_r == DDMS_ST_NORMAL)  ? 2'd1 :
                   (state_r == DDMS_ST_BRAKE)   ? 2'd2 : 2'd3;
  assign tolerance_o = par_r[12];

  ////////////////////////////////////////////////////////////////////////////
  // Profile output

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      profile_o <= '0;
    end else if (ce_i) begin
      profile_o.brake <= (state_r == DDMS_ST_BRAKE);
      if (state_r == DDMS_ST_INITIAL || ord.learn) begin
        profile_o.force_limit  <= par_r[6] + (friction_i ? friction_force_i : 32'h0000_0000);
        profile_o.energy_limit <= par_r[7];
        profile_o.speed        <= ord.open ? par_r[8] : par_r[11];
        profile_o.accel        <= par_r[10];
      end else begin
        profile_o.force_limit  <= alt_r ? par_r[0] : par_r[3];
        profile_o.energy_limit <= alt_r ? par_r[1] : par_r[4];
        profile_o.speed        <= slow_r ? par_r[9] : (alt_r ? par_r[2] : par_r[5]);
        if (slow_r) begin
          profile_o.accel <= (par_r[10] < 32'(`DDMS_SLOW_DEC_MIN)) ?
                             32'(`DDMS_SLOW_DEC_MIN) : par_r[10];
        end else begin
          profile_o.accel <= 32'(`DDMS_SLOW_ACC);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign awready = !aw_got_r && !bvalid;
  assign wready  = !w_got_r && !bvalid;
  assign arready = !rvalid;
  assign widx = aw_addr_r[5:2];
  assign ridx = araddr[5:2];
  assign wmap = (aw_addr_r[11:6] == 6'h00) && (aw_addr_r[5:2] <= 4'd14) &&
                (aw_addr_r[1:0] == 2'b00);
  assign rmap = (araddr[11:6] == 6'h00) && (araddr[5:2] <= 4'd14) &&
                (araddr[1:0] == 2'b00);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid    <= 1'b0;
      bresp     <= 2'b00;
    end else if (ce_i) begin
      if (awvalid && awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (aw_got_r && w_got_r && !bvalid) begin
        bvalid   <= 1'b1;
        bresp    <= wmap ? 2'b00 : 2'b10;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      insel_r <= DDMS_IN_END_SENSOR;
      ack_r   <= 1'b0;
      for (int i = 0; i < 13; i++) begin
        par_r[i] <= `DDMS_PAR_RST;
      end
      par_r[10] <= `DDMS_RAMP_RST;
    end else if (ce_i) begin
      ack_r <= 1'b0;
      if (aw_got_r && w_got_r && !bvalid && wmap) begin
        if (widx == 4'd0) begin
          if (w_strb_r[0]) begin
            insel_r <= ddms_insel_t'(w_data_r[1:0]);
            ack_r   <= w_data_r[`DDMS_CTRL_ACK_BIT];
          end
        end else if (widx >= 4'd2) begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb_r[b]) begin
              par_r[widx - 4'd2][b*8 +: 8] <= w_data_r[b*8 +: 8];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= 2'b00;
    end else if (ce_i) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= rmap ? 2'b00 : 2'b10;
        if (!rmap) begin
          rdata <= '0;
        end else if (ridx == 4'd0) begin
          rdata <= {30'h0, insel_r};
        end else if (ridx == 4'd1) begin
          rdata <= {16'h0000, seg_code_o, run_flt_r, blk_flt_r, dwell_flt_r, alt_r,
                    slow_r, open_ok_r, close_ok_r, sensor, state_r};
        end else begin
          rdata <= par_r[ridx - 4'd2];
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_initial_after_reset: assert property (@(posedge clk_i)
    $past(srst_i) |-> state_r == DDMS_ST_INITIAL) else $error("Not initial after reset");
  a_alt_needs_normal: assert property (@(posedge clk_i) disable iff (srst_i)
    alt_r |-> $past(state_r) != DDMS_ST_INITIAL) else $error("Alt profile outside normal");
  a_slow_needs_normal: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(slow_r) |-> $past(state_r == DDMS_ST_NORMAL && want_slow)) else $error("Slow no order");
  a_brake_on_change: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && state_r == DDMS_ST_NORMAL && moving_i && want_alt != alt_r && !run_flt_r
    |=> state_r == DDMS_ST_BRAKE) else $error("No brake on profile change");
  a_slow_dec_min: assert property (@(posedge clk_i) disable iff (srst_i)
    $past(ce_i && slow_r && state_r == DDMS_ST_NORMAL && !ord.learn)
    |-> profile_o.accel >= 32'd500) else $error("Slow decel too low");
  a_seg_overload: assert property (@(posedge clk_i) disable iff (srst_i)
    (run_flt_r || blk_flt_r) |-> seg_code_o == 4'h4) else $error("Overload code missing");
  a_fault_stops: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(run_flt_r) |-> !drive_enable_o ##1 !drive_enable_o) else $error("Drive on in fault");
  a_block_clear: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && motion_fwd_i |=> !current_nominal_o) else $error("Current not restored");
endmodule

/* logic/ddms_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 250 MHz system clock, AXI4-Lite byte addresses
// Notes:   Definitions only
`ifndef DDMS_REGS_SVH
`define DDMS_REGS_SVH

`define DDMS_CLK_MHZ          250
`define DDMS_RUN_LIMIT_S      65
`define DDMS_BLOCK_LIMIT_S    5
`define DDMS_DWELL_MIN_S      12
`define DDMS_SLOW_DEC_MIN     500
`define DDMS_SLOW_ACC         1500
`define DDMS_CYC_PER_S        (64'(`DDMS_CLK_MHZ) * 1000000)
`define DDMS_RUN_CYC          (`DDMS_RUN_LIMIT_S * `DDMS_CYC_PER_S)
`define DDMS_BLOCK_CYC        (`DDMS_BLOCK_LIMIT_S * `DDMS_CYC_PER_S)
`define DDMS_DWELL_CYC        (`DDMS_DWELL_MIN_S * `DDMS_CYC_PER_S)

`define DDMS_OFS_CTRL         12'h000
`define DDMS_OFS_STATUS       12'h004
`define DDMS_OFS_ALT_FORCE    12'h008
`define DDMS_OFS_ALT_ENERGY   12'h00C
`define DDMS_OFS_ALT_SPEED    12'h010
`define DDMS_OFS_NRM_FORCE    12'h014
`define DDMS_OFS_NRM_ENERGY   12'h018
`define DDMS_OFS_NRM_SPEED    12'h01C
`define DDMS_OFS_INI_FORCE    12'h020
`define DDMS_OFS_INI_ENERGY   12'h024
`define DDMS_OFS_INI_SPEED    12'h028
`define DDMS_OFS_SLOW_SPEED   12'h02C
`define DDMS_OFS_RAMP         12'h030
`define DDMS_OFS_INI_SPD_CLS  12'h034
`define DDMS_OFS_TOLERANCE    12'h038

`define DDMS_CTRL_SEL_LSB     0
`define DDMS_CTRL_ACK_BIT     2
`define DDMS_CTRL_RST         32'h0000_0000
`define DDMS_PAR_RST          32'h0000_0000
`define DDMS_RAMP_RST         32'h0000_01F4
`define DDMS_SEG_OVERLOAD     4'h4
`define DDMS_SEG_BLANK        4'hF

`endif

/* logic/ddms_pkg.sv */
// Purpose: Types for the door drive mode supervisor
// Assumes: Included header holds the numbers
// Notes:   Types only
package ddms_pkg;
  typedef enum logic [3:0] {
    DDMS_ST_INITIAL = 4'b0001,
    DDMS_ST_NORMAL  = 4'b0010,
    DDMS_ST_BRAKE   = 4'b0100,
    DDMS_ST_FAULT   = 4'b1000
  } ddms_state_t;

  typedef enum logic [1:0] {
    DDMS_IN_END_SENSOR   = 2'b00,
    DDMS_IN_LIGHT_CURTN  = 2'b01,
    DDMS_IN_LIGHT_BARR   = 2'b10,
    DDMS_IN_PRESS_EDGE   = 2'b11
  } ddms_insel_t;

  typedef struct packed {
    logic open;
    logic close;
    logic learn;
    logic alt_profile;
    logic slow;
    logic end_sensor;
  } ddms_order_t;

  typedef struct packed {
    logic [31:0] force_limit;
    logic [31:0] energy_limit;
    logic [31:0] speed;
    logic [31:0] accel;
    logic        brake;
  } ddms_profile_t;
endpackage

/* verification/ddms_host_model.sv */
// Purpose: Host controller stand-in issuing drive orders over the process image
// Assumes: Orders change only after a clock edge
// Notes:   Sensor bit shown only near an end stop
`timescale 1ns/1ps
module ddms_host_model (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire ddms_pkg::ddms_order_t want_i,
  input  wire logic                  near_stop_i,
  output ddms_pkg::ddms_order_t      order_o
);
  import ddms_pkg::*;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      order_o <= '0;
    end else begin
      order_o <= {want_i[5:1], want_i.end_sensor & near_stop_i};
    end
  end
endmodule

/* verification/ddms_supervisor_tb.sv */
// Purpose: Self-checking bench for the door drive mode supervisor
// Assumes: Shortened run, block and dwell counts
// Notes:   AXI4-Lite master samples handshakes 1 ns after the rising edge
`timescale 1ns/1ps
`include "ddms_regs.svh"
module ddms_supervisor_tb;
  import ddms_pkg::*;
  logic          clk_i, srst_i, ce_i, use_image_i, in_operation_i, local_input_i;
  logic          moving_i, standstill_i, blocked_i, in_obstr_area_i, motion_fwd_i;
  logic          friction_i, at_open_stop_i, at_close_stop_i, in_open_tol_i, in_close_tol_i;
  logic          near_stop, rst_seen, awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid;
  logic          drive_enable_o, current_nominal_o, hold_extend_o, restart_o;
  logic          light_curtain_o, light_barrier_o, press_edge_o;
  logic [1:0]    bresp, rresp, state_o;
  logic [3:0]    wstrb, seg_code_o;
  logic [11:0]   awaddr, araddr;
  logic [31:0]   wdata, rdata, friction_force_i, tolerance_o, rd_v;
  logic [1:0]    rsp;
  ddms_order_t   want, image_order, dig_order_i;
  ddms_profile_t profile_o;
  int            n_errors, tests_run, cyc;
  logic [11:0]   ofs [12] = '{`DDMS_OFS_ALT_FORCE, `DDMS_OFS_ALT_ENERGY, `DDMS_OFS_ALT_SPEED,
    `DDMS_OFS_NRM_FORCE, `DDMS_OFS_NRM_ENERGY, `DDMS_OFS_NRM_SPEED, `DDMS_OFS_INI_FORCE,
    `DDMS_OFS_INI_ENERGY, `DDMS_OFS_INI_SPEED, `DDMS_OFS_SLOW_SPEED, `DDMS_OFS_INI_SPD_CLS,
    `DDMS_OFS_TOLERANCE};

  ddms_supervisor #(.RUN_CYC(50), .BLOCK_CYC(20), .DWELL_CYC(30)) u_ddms_supervisor (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .image_order_i(image_order),
    .dig_order_i(dig_order_i), .use_image_i(use_image_i), .in_operation_i(in_operation_i),
    .local_input_i(local_input_i), .moving_i(moving_i), .standstill_i(standstill_i),
    .blocked_i(blocked_i), .in_obstr_area_i(in_obstr_area_i), .motion_fwd_i(motion_fwd_i),
    .friction_i(friction_i), .friction_force_i(friction_force_i),
    .at_open_stop_i(at_open_stop_i), .at_close_stop_i(at_close_stop_i),
    .in_open_tol_i(in_open_tol_i), .in_close_tol_i(in_close_tol_i),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .profile_o(profile_o), .tolerance_o(tolerance_o),
    .drive_enable_o(drive_enable_o), .current_nominal_o(current_nominal_o),
    .hold_extend_o(hold_extend_o), .restart_o(restart_o), .seg_code_o(seg_code_o),
    .light_curtain_o(light_curtain_o), .light_barrier_o(light_barrier_o),
    .press_edge_o(press_edge_o), .state_o(state_o));
  ddms_host_model u_ddms_host_model (.clk_i(clk_i), .srst_i(srst_i), .want_i(want),
    .near_stop_i(near_stop), .order_o(image_order));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (restart_o === 1'b1) rst_seen <= 1'b1;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  function automatic logic [31:0] pv(input logic [11:0] a);
    return 32'h0000_1000 | {20'h0_0000, a};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    int   t;
    @(posedge clk_i);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    bh = 1'b0;
    t = 0;
    while (!bh && t < 200) begin
      #1;
      ah = awvalid & awready; wh = wvalid & wready; bh = bvalid & bready; rsp = bresp;
      @(posedge clk_i);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
      t++;
    end
    if (!bh) chk("bvalid", 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a);
    logic ah, rh;
    int   t;
    @(posedge clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    rh = 1'b0;
    t = 0;
    while (!rh && t < 200) begin
      #1;
      ah = arvalid & arready; rh = rvalid & rready; rsp = rresp; rd_v = rdata;
      @(posedge clk_i);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
      t++;
    end
    if (!rh) chk("rvalid", 1'b1, 1'b0);
  endtask
  task automatic wait_state(input logic [1:0] s);
    int t;
    t = 0;
    while (state_o !== s && t < 200) begin
      settle(1);
      t++;
    end
  endtask
  task automatic do_reset();
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    settle(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    do_reset();
    chk("state", 2'h0, state_o);
    chk("seg", `DDMS_SEG_BLANK, seg_code_o);
    chk("enable", 1'b1, drive_enable_o);
    rd(12'h100);
    chk("rresp", 2'h2, rsp);
    chk("rdata", 32'h0000_0000, rd_v);
    wr(12'h101, 32'h0000_0001);
    chk("bresp", 2'h2, rsp);
  endtask
  task automatic t_initial();
    for (int i = 0; i < 12; i++) wr(ofs[i], pv(ofs[i]));
    for (int i = 0; i < 12; i++) begin
      rd(ofs[i]);
      chk("param", pv(ofs[i]), rd_v);
    end
    chk("tolerance", pv(`DDMS_OFS_TOLERANCE), tolerance_o);
    @(posedge clk_i);
    want <= '{close: 1'b1, default: 1'b0};
    settle(4);
    chk("ini speed cls", pv(`DDMS_OFS_INI_SPD_CLS), profile_o.speed);
    @(posedge clk_i);
    want <= '{open: 1'b1, alt_profile: 1'b1, slow: 1'b1, default: 1'b0};
    friction_i <= 1'b1;
    settle(4);
    chk("ini force", pv(`DDMS_OFS_INI_FORCE) + 32'h0000_0005, profile_o.force_limit);
    chk("ini energy", pv(`DDMS_OFS_INI_ENERGY), profile_o.energy_limit);
    chk("ini speed", pv(`DDMS_OFS_INI_SPEED), profile_o.speed);
    chk("state", 2'h0, state_o);
  endtask
  task automatic t_shortcut();
    @(posedge clk_i);
    want <= '{open: 1'b1, end_sensor: 1'b1, default: 1'b0};
    friction_i <= 1'b0; near_stop <= 1'b1; blocked_i <= 1'b1; in_obstr_area_i <= 1'b1;
    settle(8);
    chk("state", 2'h0, state_o);
    @(posedge clk_i);
    in_operation_i <= 1'b1;
    wait_state(2'h1);
    chk("state", 2'h1, state_o);
    @(posedge clk_i);
    blocked_i <= 1'b0; near_stop <= 1'b0; standstill_i <= 1'b1;
    settle(4);
    chk("nrm force", pv(`DDMS_OFS_NRM_FORCE), profile_o.force_limit);
    chk("nrm speed", pv(`DDMS_OFS_NRM_SPEED), profile_o.speed);
  endtask
  task automatic t_profiles();
    wr(`DDMS_OFS_RAMP, 32'h0000_0064);
    @(posedge clk_i);
    want.alt_profile <= 1'b1;
    settle(4);
    chk("alt force", pv(`DDMS_OFS_ALT_FORCE), profile_o.force_limit);
    chk("alt energy", pv(`DDMS_OFS_ALT_ENERGY), profile_o.energy_limit);
    chk("alt speed", pv(`DDMS_OFS_ALT_SPEED), profile_o.speed);
    @(posedge clk_i);
    moving_i <= 1'b1; standstill_i <= 1'b0; want.alt_profile <= 1'b0;
    settle(3);
    chk("state", 2'h2, state_o);
    chk("brake", 1'b1, profile_o.brake);
    @(posedge clk_i);
    moving_i <= 1'b0; standstill_i <= 1'b1;
    wait_state(2'h1);
    settle(2);
    chk("nrm force", pv(`DDMS_OFS_NRM_FORCE), profile_o.force_limit);
    @(posedge clk_i);
    moving_i <= 1'b1; standstill_i <= 1'b0; want.slow <= 1'b1;
    settle(4);
    chk("slow speed", pv(`DDMS_OFS_SLOW_SPEED), profile_o.speed);
    chk("slow decel", 32'h0000_01F4, profile_o.accel);
    @(posedge clk_i);
    want.slow <= 1'b0;
    settle(4);
    chk("accel", 32'h0000_05DC, profile_o.accel);
    chk("nrm speed", pv(`DDMS_OFS_NRM_SPEED), profile_o.speed);
    @(posedge clk_i);
    moving_i <= 1'b0; standstill_i <= 1'b1;
  endtask
  task automatic t_select();
    @(posedge clk_i);
    local_input_i <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(`DDMS_OFS_CTRL, 32'(s));
      settle(2);
      chk("route", 3'(4'b1000 >> s), {light_curtain_o, light_barrier_o, press_edge_o});
    end
    wr(`DDMS_OFS_CTRL, 32'h0000_0000);
  endtask
  task automatic t_block();
    @(posedge clk_i);
    blocked_i <= 1'b1; in_obstr_area_i <= 1'b0; motion_fwd_i <= 1'b0;
    settle(10);
    chk("nominal", 1'b0, current_nominal_o);
    settle(20);
    chk("nominal", 1'b1, current_nominal_o);
    @(posedge clk_i);
    motion_fwd_i <= 1'b1;
    settle(3);
    chk("nominal", 1'b0, current_nominal_o);
    @(posedge clk_i);
    blocked_i <= 1'b0; motion_fwd_i <= 1'b0;
    @(posedge clk_i);
    at_open_stop_i <= 1'b1;
    settle(5);
    @(posedge clk_i);
    at_open_stop_i <= 1'b0; moving_i <= 1'b1; standstill_i <= 1'b0;
    settle(2);
    chk("hold", 1'b1, hold_extend_o);
    chk("seg", `DDMS_SEG_OVERLOAD, seg_code_o);
    @(posedge clk_i);
    at_open_stop_i <= 1'b1; moving_i <= 1'b0; standstill_i <= 1'b1;
    settle(35);
    @(posedge clk_i);
    at_open_stop_i <= 1'b0; moving_i <= 1'b1; standstill_i <= 1'b0;
    settle(2);
    chk("hold", 1'b0, hold_extend_o);
    @(posedge clk_i);
    moving_i <= 1'b0; standstill_i <= 1'b1;
  endtask
  task automatic t_fault();
    @(posedge clk_i);
    moving_i <= 1'b1; standstill_i <= 1'b0; rst_seen <= 1'b0;
    settle(40);
    chk("enable", 1'b1, drive_enable_o);
    settle(20);
    chk("enable", 1'b0, drive_enable_o);
    chk("state", 2'h3, state_o);
    chk("seg", `DDMS_SEG_OVERLOAD, seg_code_o);
    wr(`DDMS_OFS_CTRL, 32'h0000_0004);
    settle(3);
    chk("restart", 1'b1, rst_seen);
    @(posedge clk_i);
    moving_i <= 1'b0; standstill_i <= 1'b1;
    do_reset();
    chk("state", 2'h0, state_o);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    {ce_i, srst_i} = 2'b11;
    {use_image_i, in_operation_i, local_input_i, moving_i, standstill_i} = '0;
    {blocked_i, in_obstr_area_i, motion_fwd_i, friction_i, near_stop} = '0;
    {at_open_stop_i, at_close_stop_i, in_open_tol_i, in_close_tol_i} = '0;
    {awvalid, wvalid, bready, arvalid, rready, rst_seen} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    want = '0;
    dig_order_i = '0;
    friction_force_i = 32'h0000_0005;
    n_errors = 0;
    tests_run = 0;
    cyc = 0;
    use_image_i = 1'b1;
    t_reset();
    t_initial();
    t_shortcut();
    t_profiles();
    t_select();
    t_block();
    t_fault();
    conclude();
  end
endmodule
